// *** rtl/simple_dma_pkg.sv ***
// shared constants for the two-channel simple dma engine
// assumes a single clock domain and register fields presented as plain ports
package simple_dma_pkg;

	// channel sequencer states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ADDR = 4'h2,
		ST_DATA = 4'h4,
		ST_RESP = 4'h8
	} dma_state_t;

	// memory-map bus encodings
	localparam logic [1:0] AXI_RESP_OKAY  = 2'h0;
	localparam logic [1:0] AXI_BURST_INCR = 2'h1;
	localparam logic [7:0] AXI_LEN_SINGLE = 8'h00;

	// reset values of status bits
	localparam logic HALTED_RESET = 1'h1;
	localparam logic IDLE_RESET   = 1'h1;

	// length field: 23 bits reach 8 MB per transfer
	localparam int unsigned LEN_W_DEFAULT  = 23;
	localparam int unsigned DATA_W_DEFAULT = 32;

	// in-memory descriptor layout, kept for a later scatter-gather engine
	localparam int unsigned DESC_BASE_WORDS  = 8;
	localparam int unsigned DESC_USER_WORDS  = 5;
	localparam int unsigned DESC_ALIGN_BYTES = 32'h40;
	localparam logic [7:0]  DESC_NEXT_OFS    = 8'h00;
	localparam logic [7:0]  DESC_BUFFER_OFS  = 8'h08;
	localparam logic [7:0]  DESC_CONTROL_OFS = 8'h18;
	localparam logic [7:0]  DESC_STATUS_OFS  = 8'h1C;
	localparam logic [7:0]  DESC_USER0_OFS   = 8'h20;
	localparam logic [7:0]  DESC_USER4_OFS   = 8'h30;
	localparam int unsigned DESC_NEXT_LSB    = 6;

endpackage : simple_dma_pkg

// *** rtl/stream_skid_buffer.sv ***
// small shift-style buffer with valid and ready on both sides
// assumes the consumer may hold ready low for any number of cycles
`timescale 1ns/1ps
`default_nettype none

module stream_skid_buffer
	import simple_dma_pkg::*;
#(
	parameter int unsigned W     = 37,
	parameter int unsigned DEPTH = 2
) (
	// clock and reset
	input  wire logic         clock_i,
	input  wire logic         rst_b_i,
	// filling side
	input  wire logic         in_valid_i,
	input  wire logic [W-1:0] in_data_i,
	output logic              in_ready_o,
	// draining side
	output logic              out_valid_o,
	output logic [W-1:0]      out_data_o,
	input  wire logic         out_ready_i
);

	if (DEPTH < 2 || DEPTH > 8) begin : g_bad_depth
		$error("stream_skid_buffer depth must be 2 to 8");
	end

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [DEPTH-1:0]        vld;
	} skid_t;

	skid_t sq;
	skid_t sn;
	logic  placed;

	// head always sits in slot 0 so the output comes straight from a flop
	always_comb begin
		sn     = sq;
		placed = 1'b0;
		if (sq.vld[0] && out_ready_i) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				sn.mem[i] = sq.mem[i+1];
			end
			sn.vld = sq.vld >> 1;
		end
		if (in_valid_i && !sq.vld[DEPTH-1]) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (!sn.vld[i] && !placed) begin
					sn.mem[i] = in_data_i;
					sn.vld[i] = 1'b1;
					placed    = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sq <= '0;
		end else begin
			sq <= sn;
		end
	end

	// ready looks at the registered state only, so a stall costs no word
	assign in_ready_o  = !sq.vld[DEPTH-1];
	assign out_valid_o = sq.vld[0];
	assign out_data_o  = sq.mem[0];

endmodule // stream_skid_buffer

`default_nettype wire

// *** rtl/simple_dma.sv ***
// two-channel simple dma: memory to stream and stream to memory
// assumes single-beat memory responses in order, tkeep packed from lane 0
`timescale 1ns/1ps
`default_nettype none

module simple_dma
	import simple_dma_pkg::*;
#(
	parameter int unsigned DATA_W                   = DATA_W_DEFAULT,
	parameter int unsigned LEN_W                    = LEN_W_DEFAULT,
	parameter bit          scatter_gather_present   = 1'b0,
	parameter bit          side_streams_present     = 1'b0,
	parameter bit          transmit_realign_present = 1'b0,
	parameter bit          receive_realign_present  = 1'b0
) (
	// clock and reset
	input  wire logic                clock_i,
	input  wire logic                rst_b_i,
	// transmit channel control
	input  wire logic                tx_run_stop_i,
	input  wire logic                tx_completion_irq_enable_i,
	input  wire logic                tx_error_irq_enable_i,
	input  wire logic                tx_flag_clear_i,
	input  wire logic [31:0]         source_address_i,
	input  wire logic [LEN_W-1:0]    transmit_length_i,
	input  wire logic                transmit_length_wr_i,
	// transmit channel status
	output logic                     tx_halted_o,
	output logic                     tx_idle_o,
	output logic                     tx_completion_irq_flag_o,
	output logic                     tx_error_flag_o,
	output logic                     tx_irq_o,
	// memory read master
	output logic [31:0]              m_axi_araddr_o,
	output logic [7:0]               m_axi_arlen_o,
	output logic [2:0]               m_axi_arsize_o,
	output logic [1:0]               m_axi_arburst_o,
	output logic                     m_axi_arvalid_o,
	input  wire logic                m_axi_arready_i,
	input  wire logic [DATA_W-1:0]   m_axi_rdata_i,
	input  wire logic [1:0]          m_axi_rresp_i,
	input  wire logic                m_axi_rvalid_i,
	output logic                     m_axi_rready_o,
	// output stream
	output logic [DATA_W-1:0]        m_axis_tdata_o,
	output logic [DATA_W/8-1:0]      m_axis_tkeep_o,
	output logic                     m_axis_tlast_o,
	output logic                     m_axis_tvalid_o,
	input  wire logic                m_axis_tready_i,
	// receive channel control
	input  wire logic                rx_run_stop_i,
	input  wire logic                rx_completion_irq_enable_i,
	input  wire logic                rx_error_irq_enable_i,
	input  wire logic                rx_flag_clear_i,
	input  wire logic [31:0]         destination_address_i,
	input  wire logic [LEN_W-1:0]    receive_length_i,
	input  wire logic                receive_length_wr_i,
	// receive channel status
	output logic                     rx_halted_o,
	output logic                     rx_idle_o,
	output logic                     rx_completion_irq_flag_o,
	output logic                     rx_error_flag_o,
	output logic                     rx_irq_o,
	output logic [LEN_W-1:0]         rx_received_bytes_o,
	// memory write master
	output logic [31:0]              m_axi_awaddr_o,
	output logic [7:0]               m_axi_awlen_o,
	output logic [2:0]               m_axi_awsize_o,
	output logic [1:0]               m_axi_awburst_o,
	output logic                     m_axi_awvalid_o,
	input  wire logic                m_axi_awready_i,
	output logic [DATA_W-1:0]        m_axi_wdata_o,
	output logic [DATA_W/8-1:0]      m_axi_wstrb_o,
	output logic                     m_axi_wlast_o,
	output logic                     m_axi_wvalid_o,
	input  wire logic                m_axi_wready_i,
	input  wire logic [1:0]          m_axi_bresp_i,
	input  wire logic                m_axi_bvalid_i,
	output logic                     m_axi_bready_o,
	// input stream
	input  wire logic [DATA_W-1:0]   s_axis_tdata_i,
	input  wire logic [DATA_W/8-1:0] s_axis_tkeep_i,
	input  wire logic                s_axis_tlast_i,
	input  wire logic                s_axis_tvalid_i,
	output logic                     s_axis_tready_o
);

	localparam int unsigned NB = DATA_W / 8;
	localparam int unsigned OW = $clog2(NB);
	localparam int unsigned CW = $clog2(2 * NB) + 1;
	localparam int unsigned BW = DATA_W + NB + 1;

	// realignment is only offered below 128-bit streams; simple mode only
	if ((DATA_W != 32 && DATA_W != 64) || LEN_W < 8 || LEN_W > 26
		|| scatter_gather_present || side_streams_present) begin : g_bad_cfg
		$error("simple_dma supports 32 or 64 bit data in simple mode only");
	end

	// byte-count helpers shared by both channels
	function automatic logic [DATA_W-1:0] byte_mask(input logic [CW-1:0] n);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < NB; i++) begin
			if (CW'(i) < n) m[i*8 +: 8] = 8'hFF;
		end
		return m;
	endfunction

	function automatic logic [NB-1:0] lane_mask(input logic [CW-1:0] lo, input logic [CW-1:0] hi);
		logic [NB-1:0] m;
		m = '0;
		for (int i = 0; i < NB; i++) begin
			m[i] = (CW'(i) >= lo) && (CW'(i) < hi);
		end
		return m;
	endfunction

	function automatic logic [CW-1:0] keep_count(input logic [NB-1:0] keep);
		logic [CW-1:0] c;
		c = '0;
		for (int i = 0; i < NB; i++) begin
			c = c + CW'(keep[i]);
		end
		return c;
	endfunction

	typedef struct packed {
		dma_state_t          state;
		logic [31:0]         addr;
		logic                first;
		logic [OW-1:0]       off;
		logic [LEN_W-1:0]    rd_rem;
		logic [LEN_W-1:0]    out_rem;
		logic [2*DATA_W-1:0] acc;
		logic [CW-1:0]       cnt;
		logic                arvalid;
		logic                rready;
		logic                done;
		logic                err;
		logic                irq;
		logic                halted;
		logic                idle;
	} tx_t;

	typedef struct packed {
		dma_state_t          state;
		logic [31:0]         addr;
		logic [31:0]         awaddr;
		logic [OW-1:0]       lo;
		logic [2*DATA_W-1:0] acc;
		logic [CW-1:0]       cnt;
		logic                got_last;
		logic [LEN_W-1:0]    rcvd;
		logic                awvalid;
		logic                wvalid;
		logic [DATA_W-1:0]   wdata;
		logic [NB-1:0]       wstrb;
		logic                bready;
		logic                tready;
		logic                done;
		logic                err;
		logic                irq;
		logic                halted;
		logic                idle;
	} rx_t;

	tx_t           tq, tn;
	rx_t           rq, rn;
	logic          tx_start, tx_set, tx_err, t_push, t_last, buf_ready;
	logic [CW-1:0] t_emit_n, t_avail, t_take;
	logic [OW-1:0] t_skip;
	logic [DATA_W-1:0] t_word, r_data;
	logic          rx_start, rx_set, rx_err, r_check;
	logic [CW-1:0] r_k, r_e;

	// start decode: zero length or stopped channel leaves the channel idle
	assign tx_start = (tq.state == ST_IDLE) && transmit_length_wr_i
		&& (transmit_length_i != '0) && tx_run_stop_i;
	assign rx_start = (rq.state == ST_IDLE) && receive_length_wr_i
		&& (receive_length_i != '0) && rx_run_stop_i;

	// transmit: one outstanding single-beat read, byte accumulator feeds the buffer
	always_comb begin
		tn       = tq;
		tx_set   = 1'b0;
		tx_err   = 1'b0;
		t_emit_n = (tq.cnt >= CW'(NB)) ? CW'(NB) : tq.cnt;
		t_push   = (tq.cnt >= CW'(NB)) || (tq.rd_rem == '0 && tq.cnt != '0);
		t_last   = (tq.out_rem == LEN_W'(t_emit_n));
		if (t_push && buf_ready) begin
			tn.acc     = tq.acc >> DATA_W;
			tn.cnt     = tq.cnt - t_emit_n;
			tn.out_rem = tq.out_rem - LEN_W'(t_emit_n);
		end
		t_skip  = tq.first ? tq.off : '0;
		t_avail = CW'(NB) - CW'(t_skip);
		t_take  = (tq.rd_rem < LEN_W'(t_avail)) ? CW'(tq.rd_rem) : t_avail;
		t_word  = (m_axi_rdata_i >> {t_skip, 3'h0}) & byte_mask(t_take);
		case (tq.state)
			ST_IDLE: begin
				if (tx_start) begin
					tn.state   = ST_ADDR;
					tn.addr    = {source_address_i[31:OW], {OW{1'b0}}};
					tn.off     = transmit_realign_present ? source_address_i[OW-1:0] : '0;
					tn.first   = 1'b1;
					tn.rd_rem  = transmit_length_i;
					tn.out_rem = transmit_length_i;
					tn.acc     = '0;
					tn.cnt     = '0;
					tn.arvalid = 1'b1;
				end
			end
			ST_ADDR: begin
				if (m_axi_arready_i) begin
					tn.arvalid = 1'b0;
					tn.state   = ST_DATA;
					tn.rready  = (tn.cnt <= CW'(NB));
				end
			end
			ST_DATA: begin
				if (m_axi_rvalid_i && tq.rready) begin
					tn.acc    = tn.acc | ({{DATA_W{1'b0}}, t_word} << {tn.cnt, 3'h0});
					tn.cnt    = tn.cnt + t_take;
					tn.rd_rem = tq.rd_rem - LEN_W'(t_take);
					tn.first  = 1'b0;
					tn.addr   = tq.addr + 32'(NB);
					tn.rready = 1'b0;
					tx_err    = (m_axi_rresp_i != AXI_RESP_OKAY);
					if (tn.rd_rem != '0) begin
						tn.state   = ST_ADDR;
						tn.arvalid = 1'b1;
					end else begin
						tn.state = ST_RESP;
					end
				end else begin
					// room for a whole word must exist before the beat is taken
					tn.rready = (tn.cnt <= CW'(NB));
				end
			end
			ST_RESP: begin
				// done once the last byte sits in the buffer
				if (tn.out_rem == '0) begin
					tn.state = ST_IDLE;
					tx_set   = 1'b1;
				end
			end
			default: tn.state = ST_IDLE;
		endcase
		tn.done   = tx_set | (tq.done & ~tx_flag_clear_i);
		tn.err    = tx_err | (tq.err & ~tx_flag_clear_i);
		tn.irq    = (tn.done & tx_completion_irq_enable_i)
			| (tn.err & tx_error_irq_enable_i);
		tn.halted = !tx_run_stop_i && (tn.state == ST_IDLE);
		tn.idle   = (tn.state == ST_IDLE);
	end

	// receive: collect stream bytes, write strobed words at the lane offset
	always_comb begin
		rn      = rq;
		rx_set  = 1'b0;
		rx_err  = 1'b0;
		r_check = 1'b0;
		r_k     = keep_count(s_axis_tkeep_i);
		r_data  = s_axis_tdata_i & byte_mask(r_k);
		r_e     = '0;
		case (rq.state)
			ST_IDLE: begin
				if (rx_start) begin
					rn.state    = ST_DATA;
					rn.addr     = {destination_address_i[31:OW], {OW{1'b0}}};
					rn.lo       = receive_realign_present ? destination_address_i[OW-1:0] : '0;
					rn.cnt      = CW'(rn.lo);
					rn.acc      = '0;
					rn.got_last = 1'b0;
					rn.rcvd     = '0;
					rn.tready   = 1'b1;
				end
			end
			ST_DATA: begin
				if (s_axis_tvalid_i && rq.tready) begin
					rn.acc      = rq.acc | ({{DATA_W{1'b0}}, r_data} << {rq.cnt, 3'h0});
					rn.cnt      = rq.cnt + r_k;
					rn.rcvd     = rq.rcvd + LEN_W'(r_k);
					rn.got_last = s_axis_tlast_i;
					r_check     = 1'b1;
				end
			end
			ST_ADDR: begin
				if (m_axi_awready_i) rn.awvalid = 1'b0;
				if (m_axi_wready_i) rn.wvalid = 1'b0;
				if (!rn.awvalid && !rn.wvalid) begin
					rn.state  = ST_RESP;
					rn.bready = 1'b1;
				end
			end
			ST_RESP: begin
				if (m_axi_bvalid_i) begin
					rn.bready = 1'b0;
					rx_err    = (m_axi_bresp_i != AXI_RESP_OKAY);
					r_check   = 1'b1;
				end
			end
			default: rn.state = ST_IDLE;
		endcase
		// one write per full word, or the tail once the packet has ended
		if (r_check) begin
			if (rn.cnt >= CW'(NB) || (rn.got_last && rn.cnt > CW'(rn.lo))) begin
				r_e        = (rn.cnt >= CW'(NB)) ? CW'(NB) : rn.cnt;
				rn.state   = ST_ADDR;
				rn.awvalid = 1'b1;
				rn.wvalid  = 1'b1;
				rn.wdata   = rn.acc[DATA_W-1:0];
				rn.wstrb   = lane_mask(CW'(rn.lo), r_e);
				rn.acc     = rn.acc >> DATA_W;
				rn.cnt     = rn.cnt - r_e;
				rn.lo      = '0;
				rn.awaddr  = rq.addr;                           // held while awvalid
				rn.addr    = rq.addr + 32'(NB);
				rn.tready  = 1'b0;
			end else if (rn.got_last) begin
				rn.state  = ST_IDLE;
				rn.tready = 1'b0;
				rx_set    = 1'b1;
			end else begin
				rn.state  = ST_DATA;
				rn.tready = 1'b1;
			end
		end
		rn.done   = rx_set | (rq.done & ~rx_flag_clear_i);
		rn.err    = rx_err | (rq.err & ~rx_flag_clear_i);
		rn.irq    = (rn.done & rx_completion_irq_enable_i)
			| (rn.err & rx_error_irq_enable_i);
		rn.halted = !rx_run_stop_i && (rn.state == ST_IDLE);
		rn.idle   = (rn.state == ST_IDLE);
	end

	// channel state registers
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tq        <= '0;
			tq.state  <= ST_IDLE;
			tq.halted <= HALTED_RESET;
			tq.idle   <= IDLE_RESET;
			rq        <= '0;
			rq.state  <= ST_IDLE;
			rq.halted <= HALTED_RESET;
			rq.idle   <= IDLE_RESET;
		end else begin
			tq <= tn;
			rq <= rn;
		end
	end

	// two-entry buffer absorbs a stalled stream receiver
	stream_skid_buffer #(.W(BW), .DEPTH(2)) u_tx_buffer (
		.clock_i     (clock_i),
		.rst_b_i     (rst_b_i),
		.in_valid_i  (t_push),
		.in_data_i   ({t_last, lane_mask('0, t_emit_n), tq.acc[DATA_W-1:0]}),
		.in_ready_o  (buf_ready),
		.out_valid_o (m_axis_tvalid_o),
		.out_data_o  ({m_axis_tlast_o, m_axis_tkeep_o, m_axis_tdata_o}),
		.out_ready_i (m_axis_tready_i)
	);

	// register-driven outputs and fixed single-beat burst shape
	assign m_axi_araddr_o  = tq.addr;
	assign m_axi_arvalid_o = tq.arvalid;
	assign m_axi_rready_o  = tq.rready;
	assign m_axi_arlen_o   = AXI_LEN_SINGLE;
	assign m_axi_arsize_o  = 3'(OW);
	assign m_axi_arburst_o = AXI_BURST_INCR;
	assign m_axi_awaddr_o  = rq.awaddr;
	assign m_axi_awvalid_o = rq.awvalid;
	assign m_axi_wdata_o   = rq.wdata;
	assign m_axi_wstrb_o   = rq.wstrb;
	assign m_axi_wvalid_o  = rq.wvalid;
	assign m_axi_wlast_o   = 1'b1;
	assign m_axi_bready_o  = rq.bready;
	assign m_axi_awlen_o   = AXI_LEN_SINGLE;
	assign m_axi_awsize_o  = 3'(OW);
	assign m_axi_awburst_o = AXI_BURST_INCR;
	assign s_axis_tready_o = rq.tready;
	assign tx_halted_o              = tq.halted;
	assign tx_idle_o                = tq.idle;
	assign tx_completion_irq_flag_o = tq.done;
	assign tx_error_flag_o          = tq.err;
	assign tx_irq_o                 = tq.irq;
	assign rx_halted_o              = rq.halted;
	assign rx_idle_o                = rq.idle;
	assign rx_completion_irq_flag_o = rq.done;
	assign rx_error_flag_o          = rq.err;
	assign rx_irq_o                 = rq.irq;
	assign rx_received_bytes_o      = rq.rcvd;

	// helper for the byte-total check on the output stream
	logic [LEN_W-1:0] chk_sent_q, chk_len_q;
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			chk_sent_q <= '0;
			chk_len_q  <= '0;
		end else if (tx_start) begin
			chk_sent_q <= '0;
			chk_len_q  <= transmit_length_i;
		end else if (m_axis_tvalid_o && m_axis_tready_i) begin
			chk_sent_q <= chk_sent_q + LEN_W'(keep_count(m_axis_tkeep_o));
		end
	end

	AST_TX_ZERO_LEN: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(tq.state == ST_IDLE && transmit_length_wr_i && transmit_length_i == '0)
		|=> (tx_idle_o && !m_axi_arvalid_o)) else $error("zero length started a read");
	AST_TX_START: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		tx_start |=> (!tx_idle_o && m_axi_arvalid_o)) else $error("transmit did not start");
	AST_TX_STOPPED: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(tq.state == ST_IDLE && !tx_run_stop_i && transmit_length_wr_i)
		|=> (tx_idle_o && !m_axi_arvalid_o)) else $error("stopped channel started");
	AST_TX_RUN: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		tx_run_stop_i |=> !tx_halted_o) else $error("halted while running");
	AST_TX_IRQ: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		($rose(tx_completion_irq_flag_o) && $past(tx_completion_irq_enable_i)) |-> tx_irq_o)
		else $error("completion did not raise interrupt");
	AST_TX_SET_WINS: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(tx_set && tx_flag_clear_i) |=> tx_completion_irq_flag_o) else $error("completion lost");
	AST_TX_BYTES: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(m_axis_tvalid_o && m_axis_tready_i && m_axis_tlast_o)
		|-> (chk_sent_q + LEN_W'(keep_count(m_axis_tkeep_o)) == chk_len_q))
		else $error("stream byte total differs from length");
	AST_ADDR_ALIGN: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(m_axi_arvalid_o || m_axi_awvalid_o)
		|-> (m_axi_araddr_o[OW-1:0] == '0 && m_axi_awaddr_o[OW-1:0] == '0))
		else $error("memory address not word aligned");
	AST_RX_NO_REALIGN: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		(!receive_realign_present && m_axi_wvalid_o) |-> m_axi_wstrb_o[0])
		else $error("strobe offset without realignment");
	AST_RX_START: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		rx_start |=> (s_axis_tready_o && !rx_idle_o && rx_received_bytes_o == '0))
		else $error("receive did not start");
	AST_RX_IDLE_STALL: assert property (@(posedge clock_i) disable iff (!rst_b_i)
		rx_idle_o |-> !s_axis_tready_o) else $error("idle receiver took stream data");

endmodule // simple_dma

`default_nettype wire

// *** tb/dma_mem_model.sv ***
// memory slave and stream sink facing the dma's masters
// assumes single-beat bursts and the bench's clock and reset
`timescale 1ns/1ps
`default_nettype none
module dma_mem_model
	import simple_dma_pkg::*;
(
	// clock, reset, read error request
	input  wire logic        clock_i, rst_b_i, err_i,
	// read slave
	input  wire logic [31:0] m_axi_araddr_o,
	input  wire logic        m_axi_arvalid_o, m_axi_rready_o,
	output logic             m_axi_arready_i, m_axi_rvalid_i,
	output logic [31:0]      m_axi_rdata_i,
	output logic [1:0]       m_axi_rresp_i, m_axi_bresp_i,
	// write slave and stream sink
	input  wire logic        m_axi_wvalid_o, m_axi_bready_o,
	output logic             m_axi_awready_i, m_axi_wready_i, m_axi_bvalid_i, m_axis_tready_i
);
	logic [31:0] raddr_q;
	// idle read lines carry the inverse so a stale word never passes
	assign m_axi_rdata_i   = m_axi_rvalid_i ? raddr_q : ~raddr_q;
	assign m_axi_rresp_i   = err_i ? 2'h2 : AXI_RESP_OKAY;
	assign m_axi_bresp_i   = AXI_RESP_OKAY;
	assign m_axi_awready_i = 1'h1;
	// read and write-data readies a cycle late, awready always high; sink stalls every other cycle
	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			{m_axi_arready_i, m_axi_rvalid_i, m_axi_wready_i, m_axi_bvalid_i} <= 4'h0;
			{m_axis_tready_i, raddr_q} <= 33'h0;
		end else begin
			m_axi_arready_i <= m_axi_arvalid_o && !m_axi_arready_i;
			m_axi_wready_i  <= m_axi_wvalid_o && !m_axi_wready_i;
			m_axis_tready_i <= !m_axis_tready_i;
			if (m_axi_arvalid_o && m_axi_arready_i) begin
				{raddr_q, m_axi_rvalid_i} <= {m_axi_araddr_o, 1'h1};
			end else if (m_axi_rready_o) begin
				m_axi_rvalid_i <= 1'h0;
			end
			if (m_axi_wvalid_o && m_axi_wready_i) begin
				m_axi_bvalid_i <= 1'h1;
			end else if (m_axi_bready_o) begin
				m_axi_bvalid_i <= 1'h0;
			end
		end
	end
endmodule // dma_mem_model
`default_nettype wire

// *** tb/tb_top.sv ***
// bench: reset, refused starts, transmit runs, one receive run
// assumes default widths with realignment left out
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clock_i = 1'h0, rst_b_i = 1'h0, err_i = 1'h0, tx_run_stop_i = 1'h0, rx_run_stop_i = 1'h0;
	logic tx_completion_irq_enable_i = 1'h0, rx_completion_irq_enable_i = 1'h0;
	logic tx_error_irq_enable_i = 1'h0, rx_error_irq_enable_i = 1'h0, tx_flag_clear_i = 1'h0;
	logic rx_flag_clear_i = 1'h0, transmit_length_wr_i = 1'h0, receive_length_wr_i = 1'h0;
	logic [22:0] transmit_length_i = 23'h0, receive_length_i = 23'h0, rx_received_bytes_o;
	logic [31:0] source_address_i = 32'h0, destination_address_i = 32'h0, s_axis_tdata_i = 32'h0;
	logic [3:0] s_axis_tkeep_i = 4'h0, m_axis_tkeep_o, m_axi_wstrb_o, wstrb_q;
	logic s_axis_tlast_i = 1'h0, s_axis_tvalid_i = 1'h0, last_q;
	logic tx_halted_o, tx_idle_o, tx_completion_irq_flag_o, tx_error_flag_o, tx_irq_o;
	logic rx_halted_o, rx_idle_o, rx_completion_irq_flag_o, rx_error_flag_o, rx_irq_o;
	logic [31:0] m_axi_araddr_o, m_axi_rdata_i, m_axis_tdata_o, m_axi_awaddr_o, m_axi_wdata_o;
	logic [31:0] first_q, awaddr_q, wdata_q;
	logic [7:0] m_axi_arlen_o, m_axi_awlen_o;
	logic [2:0] m_axi_arsize_o, m_axi_awsize_o;
	logic [1:0] m_axi_arburst_o, m_axi_awburst_o, m_axi_rresp_i, m_axi_bresp_i;
	logic m_axi_arvalid_o, m_axi_arready_i, m_axi_rvalid_i, m_axi_rready_o, m_axis_tlast_o;
	logic m_axis_tvalid_o, m_axis_tready_i, m_axi_awvalid_o, m_axi_awready_i, m_axi_wlast_o;
	logic m_axi_wvalid_o, m_axi_wready_i, m_axi_bvalid_i, m_axi_bready_o, s_axis_tready_o;
	int fail_count = 0, checks_done = 0, nb = 0, want = 0;
	simple_dma dut (.*);
	dma_mem_model mem (.*);
	always #2 clock_i = ~clock_i;
	// bus watcher: first stream word, byte total, last write seen
	always @(posedge clock_i) begin
		if (transmit_length_wr_i === 1'h1) begin
			nb <= 0;
		end else if (m_axis_tvalid_o === 1'h1 && m_axis_tready_i === 1'h1) begin
			if (nb == 0) first_q <= m_axis_tdata_o;
			nb <= nb + $countones(m_axis_tkeep_o);
			last_q <= m_axis_tlast_o;
		end
		if (m_axi_wvalid_o === 1'h1 && m_axi_wready_i === 1'h1) begin
			{wstrb_q, wdata_q} <= {m_axi_wstrb_o, m_axi_wdata_o};
		end
		if (m_axi_awvalid_o === 1'h1) awaddr_q <= m_axi_awaddr_o;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// bounded wait for a channel to finish; a hang ends the run
	task automatic settle(input bit rx);
		for (int i = 0; i < 400; i++) begin
			@(negedge clock_i);
			if (rx ? rx_idle_o === 1'h1 : (tx_idle_o === 1'h1 && nb == want)) return;
		end
		fail_count++;
		conclude();
	endtask
	task automatic tx_go(input logic [31:0] a, input logic [22:0] n);
		{source_address_i, transmit_length_i, transmit_length_wr_i} = {a, n, 1'h1};
		@(negedge clock_i);
		transmit_length_wr_i = 1'h0;
	endtask
	task automatic rx_go(input logic [31:0] a, input logic [22:0] n);
		{destination_address_i, receive_length_i, receive_length_wr_i} = {a, n, 1'h1};
		@(negedge clock_i);
		receive_length_wr_i = 1'h0;
	endtask
	// valid held until the edge that sees ready; only the last beat then drops valid, with data inverted
	task automatic beat(input logic [31:0] d, input logic [3:0] k, input logic l);
		int i;
		{s_axis_tdata_i, s_axis_tkeep_i, s_axis_tlast_i, s_axis_tvalid_i} = {d, k, l, 1'h1};
		for (i = 0; i < 50; i++) begin
			if (s_axis_tready_o === 1'h1) break;
			@(negedge clock_i);
		end
		check(i < 50, 1'h1);
		if (i >= 50) conclude();
		@(negedge clock_i);
		if (l) {s_axis_tvalid_i, s_axis_tdata_i} = {1'h0, ~d};
	endtask
	task automatic s_idle();
		check({tx_halted_o, tx_idle_o, rx_halted_o, rx_idle_o, tx_irq_o, rx_irq_o}, 6'h3C);
		check(simple_dma_pkg::DESC_ALIGN_BYTES, 32'h40);
		check({simple_dma_pkg::DESC_NEXT_OFS, simple_dma_pkg::DESC_STATUS_OFS}, 16'h001C);
		check(simple_dma_pkg::DESC_NEXT_LSB, 32'd6);
		tx_go(32'h100, 23'h4);
		check({tx_idle_o, m_axi_arvalid_o}, 2'h2);
		{tx_run_stop_i, rx_run_stop_i, tx_error_irq_enable_i, rx_completion_irq_enable_i} = 4'hF;
		@(negedge clock_i);
		check({tx_halted_o, rx_halted_o}, 2'h0);
		tx_go(32'h100, 23'h0);
		rx_go(32'h200, 23'h0);
		check({tx_idle_o, rx_idle_o, s_axis_tready_o, m_axi_arvalid_o}, 4'hC);
	endtask
	// hold keeps the clear high across completion: set wins, then clear
	task automatic s_tx(input logic e, input logic ien, input logic hold);
		{tx_flag_clear_i, tx_completion_irq_enable_i, err_i, want} = {1'h1, ien, e, 32'd10};
		@(negedge clock_i);
		tx_flag_clear_i = hold;
		check({tx_completion_irq_flag_o, tx_error_flag_o, tx_irq_o}, 3'h0);
		tx_go(32'h104, 23'hA);
		settle(1'h0);
		@(negedge clock_i);
		check(first_q, 32'h104);
		check(nb, 32'd10);
		check(last_q, 1'h1);
		check({tx_completion_irq_flag_o, tx_error_flag_o, tx_irq_o}, {~hold, e, ien | e});
	endtask
	task automatic s_rx();
		rx_go(32'h200, 23'h10);
		beat(32'h44332211, 4'hF, 1'h0);
		beat(32'h00006655, 4'h3, 1'h1);
		settle(1'h1);
		check({rx_received_bytes_o, wstrb_q}, {23'h6, 4'h3});
		check(awaddr_q, 32'h204);
		check(wdata_q[15:0], 16'h6655);
		check({m_axi_arlen_o, m_axi_awlen_o}, 16'h0000);
		check({m_axi_arsize_o, m_axi_arburst_o}, 5'h09);
		check({m_axi_awsize_o, m_axi_awburst_o, m_axi_wlast_o}, 6'h13);
		check({rx_completion_irq_flag_o, rx_error_flag_o, rx_irq_o}, 3'h5);
	endtask
	initial begin
		repeat (3) @(negedge clock_i);
		rst_b_i = 1'h1;
		s_idle();
		s_tx(1'h0, 1'h1, 1'h0);
		s_tx(1'h1, 1'h0, 1'h0);
		s_tx(1'h0, 1'h0, 1'h1);
		s_rx();
		conclude();
	end
endmodule // tb_top
`default_nettype wire
